// ===== design/p1fs_params.svh
`ifndef P1FS_PARAMS_SVH
`define P1FS_PARAMS_SVH

// Register indices; byte address is four times the index
`define P1FS_DIR_IDX 16'hff80
`define P1FS_DATA_IDX 16'hff82
`define P1FS_CTRL_IDX 16'hfffc

// Reset and standby values, reserved control mask and direction read value
`define P1FS_CTRL_RST 8'h87
`define P1FS_DIR_RST 8'h03
`define P1FS_DIR_HWSTBY 8'h00
`define P1FS_DATA_RST 8'h00
`define P1FS_CTRL_RSVD 8'h87
`define P1FS_DIR_READ 8'hff

// Control field positions
`define P1FS_EXT_INTERRUPT_LINE1_BIT 6
`define P1FS_EXT_INTERRUPT_LINE0_BIT 5
`define P1FS_NMI_BIT 4
`define P1FS_BUS_RELEASE_SELECT_BIT 3

// Pin numbers with alternate roles
`define P1FS_PIN_TMR 7
`define P1FS_PIN_EXT_INTERRUPT_LINE1 6
`define P1FS_PIN_EXT_INTERRUPT_LINE0 5
`define P1FS_PIN_WAIT 4
`define P1FS_PIN_BUS_REQUEST_IN 3
`define P1FS_PIN_BACK 2
`define P1FS_PIN_ECLK 1
`define P1FS_PIN_SCLK 0

`endif

// ===== design/p1fs_pkg.sv
package p1fs_pkg;

	typedef enum logic [1:0] {
		P1FS_SEL_NONE,
		P1FS_SEL_DIR,
		P1FS_SEL_DATA,
		P1FS_SEL_CTRL
	} p1fs_sel_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
	} p1fs_pin_t;

	typedef struct packed {
		logic ext_interrupt_line1_n;
		logic ext_interrupt_line0_n;
		logic wait_n;
		logic bus_request_in_n;
		logic nmi_req;
	} p1fs_alt_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] dir;
		logic [7:0] latch;
		logic nmi_prev;
		logic wr_pend;
		p1fs_sel_t wr_sel;
		logic [31:0] rdata;
		p1fs_pin_t pin;
		p1fs_alt_t alt;
	} p1fs_state_t;

endpackage

// ===== design/p1fs_top.sv
`timescale 1ns/1ns
`include "p1fs_params.svh"
// Contract
// - Control register loads 0x87 on reset and on hardware standby.
// - Software standby leaves the control register unchanged.
// - Control bits 7 and 2..0 ignore writes and read as one.
// - Line-1 select makes pin 6 the line-1 interrupt input.
// - Line-0 select makes pin 5 the line-0 interrupt input.
// - Interrupt-claimed pins still read their live level in data.
// - NMI on falling edge when edge bit is 0, rising when 1.
// - Bus release in expanded mode: pin 3 request in, pin 2 ack out.
// - Bus release select only takes effect in expanded modes.
// - Single-chip mode keeps pins 3 and 2 as plain I/O.
// - Any timer output select bit set drives pin 7 with compare output.
// - Expanded mode with wait select high makes pin 4 the wait input.
// - Bus release roles of pins 3 and 2 ignore direction bits.
// - Unclaimed pin is output when direction bit is 1, else input.
// - Output pins 1 and 0 carry E clock and system clock.
// - Data read gives latch for plain outputs, clock for output pins 1 and 0, pin level for inputs and alternate outputs.
// - Direction register loads 0x03 on reset.
module p1fs_top
	import p1fs_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic MODE_EXP,
	input wire logic HW_STBY,
	input wire logic SW_STBY,
	input wire logic [3:0] TIMER_OUTPUT_SELECT,
	input wire logic TIMER_COMPARE_OUTPUT,
	input wire logic WAIT_MODE_SELECT_HIGH,
	input wire logic BUS_ACK_OUT,
	input wire logic E_CLK,
	input wire logic SYS_CLK,
	input wire logic NMI_PIN,
	input wire logic [7:0] PIN_IN,
	output logic [7:0] PIN_OUT,
	output logic [7:0] PIN_OE_N,
	output logic EXT_INTERRUPT_LINE1_N,
	output logic EXT_INTERRUPT_LINE0_N,
	output logic WAIT_IN_N,
	output logic BUS_REQUEST_IN_N,
	output logic NMI_REQ
);

	p1fs_state_t s_r;
	p1fs_state_t s_nxt;

	logic [7:0] claim_in;
	logic [7:0] claim_out;
	logic [7:0] alt_val;
	logic [7:0] drv_oe;
	logic [7:0] drv_val;
	logic [7:0] rd_pins;
	logic ext_interrupt_line1_sel;
	logic ext_interrupt_line0_sel;
	logic nmi_rise;
	logic bus_release_select_on;
	logic wait_on;
	logic tmr_on;
	logic addr_take;

	function automatic p1fs_sel_t decode(input logic [31:0] a);
		p1fs_sel_t r;
		r = P1FS_SEL_NONE;
		if (a[31:18] == 14'h0000 && a[1:0] == 2'h0) begin
			if (a[17:2] == `P1FS_DIR_IDX)
				r = P1FS_SEL_DIR;
			else if (a[17:2] == `P1FS_DATA_IDX)
				r = P1FS_SEL_DATA;
			else if (a[17:2] == `P1FS_CTRL_IDX)
				r = P1FS_SEL_CTRL;
		end
		return r;
	endfunction

	// Zero-wait slave; a low enable stretches the transfer instead
	assign HREADYOUT = CE;
	assign HRESP = 1'b0;
	assign addr_take = HSEL && HTRANS[1] && HREADY;

	assign ext_interrupt_line1_sel = s_r.ctrl[`P1FS_EXT_INTERRUPT_LINE1_BIT];
	assign ext_interrupt_line0_sel = s_r.ctrl[`P1FS_EXT_INTERRUPT_LINE0_BIT];
	assign nmi_rise = s_r.ctrl[`P1FS_NMI_BIT];
	// Mode gates the bus and wait roles only
	assign bus_release_select_on = MODE_EXP && s_r.ctrl[`P1FS_BUS_RELEASE_SELECT_BIT];
	assign wait_on = MODE_EXP && WAIT_MODE_SELECT_HIGH;
	assign tmr_on = |TIMER_OUTPUT_SELECT;

	always_comb begin
		claim_in = 8'h00;
		claim_out = 8'h00;
		alt_val = 8'h00;
		claim_in[`P1FS_PIN_EXT_INTERRUPT_LINE1] = ext_interrupt_line1_sel;
		claim_in[`P1FS_PIN_EXT_INTERRUPT_LINE0] = ext_interrupt_line0_sel;
		claim_in[`P1FS_PIN_WAIT] = wait_on;
		claim_in[`P1FS_PIN_BUS_REQUEST_IN] = bus_release_select_on;
		claim_out[`P1FS_PIN_BACK] = bus_release_select_on;
		alt_val[`P1FS_PIN_BACK] = BUS_ACK_OUT;
		claim_out[`P1FS_PIN_TMR] = tmr_on;
		alt_val[`P1FS_PIN_TMR] = TIMER_COMPARE_OUTPUT;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			logic plain_val;
			if (gi == `P1FS_PIN_ECLK) begin : g_e
				assign plain_val = E_CLK;
			end else if (gi == `P1FS_PIN_SCLK) begin : g_s
				assign plain_val = SYS_CLK;
			end else begin : g_l
				assign plain_val = s_r.latch[gi];
			end
			// Alternate roles win over the direction bit
			assign drv_oe[gi] = !claim_in[gi] &&
				(claim_out[gi] || s_r.dir[gi]);
			assign drv_val[gi] = claim_out[gi] ? alt_val[gi] :
				plain_val;
			// Claimed or input pins read the live level
			assign rd_pins[gi] = (drv_oe[gi] && !claim_out[gi]) ?
				plain_val : PIN_IN[gi];
		end
	endgenerate

	always_comb begin
		s_nxt = s_r;
		s_nxt.alt.nmi_req = 1'b0;
		// Finish a pending write in its data phase
		if (s_r.wr_pend) begin
			s_nxt.wr_pend = 1'b0;
			case (s_r.wr_sel)
				P1FS_SEL_DIR: begin
					s_nxt.dir = HWDATA[7:0];
				end
				P1FS_SEL_DATA: begin
					// Clock pin bits are read-only
					s_nxt.latch = {HWDATA[7:2], 2'b00};
				end
				P1FS_SEL_CTRL: begin
					s_nxt.ctrl = (HWDATA[7:0] & ~`P1FS_CTRL_RSVD) |
						`P1FS_CTRL_RSVD;
				end
				default: begin
				end
			endcase
		end
		// Software standby has no reload path here
		if (HW_STBY) begin
			s_nxt.ctrl = `P1FS_CTRL_RST;
			s_nxt.dir = `P1FS_DIR_HWSTBY;
			s_nxt.latch = `P1FS_DATA_RST;
			s_nxt.wr_pend = 1'b0;
		end
		if (addr_take) begin
			s_nxt.wr_pend = HWRITE && decode(HADDR) != P1FS_SEL_NONE;
			s_nxt.wr_sel = decode(HADDR);
			// Control read data uses post-write values; data reads use the pre-write latch and direction
			case (decode(HADDR))
				P1FS_SEL_DIR: begin
					s_nxt.rdata = {24'h000000, `P1FS_DIR_READ};
				end
				P1FS_SEL_DATA: begin
					s_nxt.rdata = {24'h000000, rd_pins};
				end
				P1FS_SEL_CTRL: begin
					s_nxt.rdata = {24'h000000,
						s_nxt.ctrl | `P1FS_CTRL_RSVD};
				end
				default: begin
					s_nxt.rdata = 32'h00000000;
				end
			endcase
		end
		s_nxt.nmi_prev = NMI_PIN;
		if (NMI_PIN != s_r.nmi_prev && NMI_PIN == nmi_rise)
			s_nxt.alt.nmi_req = 1'b1;
		s_nxt.pin.oe_n = ~drv_oe;
		s_nxt.pin.out = drv_val;
		s_nxt.alt.ext_interrupt_line1_n = ext_interrupt_line1_sel ?
			PIN_IN[`P1FS_PIN_EXT_INTERRUPT_LINE1] : 1'b1;
		s_nxt.alt.ext_interrupt_line0_n = ext_interrupt_line0_sel ?
			PIN_IN[`P1FS_PIN_EXT_INTERRUPT_LINE0] : 1'b1;
		s_nxt.alt.wait_n = wait_on ?
			PIN_IN[`P1FS_PIN_WAIT] : 1'b1;
		s_nxt.alt.bus_request_in_n = bus_release_select_on ?
			PIN_IN[`P1FS_PIN_BUS_REQUEST_IN] : 1'b1;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_r.ctrl <= `P1FS_CTRL_RST;
			s_r.dir <= `P1FS_DIR_RST;
			s_r.latch <= `P1FS_DATA_RST;
			s_r.nmi_prev <= 1'b1;
			s_r.wr_pend <= 1'b0;
			s_r.wr_sel <= P1FS_SEL_NONE;
			s_r.rdata <= 32'h00000000;
			s_r.pin.out <= 8'h00;
			s_r.pin.oe_n <= 8'hff;
			s_r.alt.ext_interrupt_line1_n <= 1'b1;
			s_r.alt.ext_interrupt_line0_n <= 1'b1;
			s_r.alt.wait_n <= 1'b1;
			s_r.alt.bus_request_in_n <= 1'b1;
			s_r.alt.nmi_req <= 1'b0;
		end else if (CE) begin
			s_r <= s_nxt;
		end
	end

	assign HRDATA = s_r.rdata;
	assign PIN_OUT = s_r.pin.out;
	assign PIN_OE_N = s_r.pin.oe_n;
	assign EXT_INTERRUPT_LINE1_N = s_r.alt.ext_interrupt_line1_n;
	assign EXT_INTERRUPT_LINE0_N = s_r.alt.ext_interrupt_line0_n;
	assign WAIT_IN_N = s_r.alt.wait_n;
	assign BUS_REQUEST_IN_N = s_r.alt.bus_request_in_n;
	assign NMI_REQ = s_r.alt.nmi_req;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	chk_stby_reload: assert property (
		CE && HW_STBY |=> s_r.ctrl == `P1FS_CTRL_RST &&
			s_r.dir == `P1FS_DIR_HWSTBY)
		else $error("standby did not reload registers");

	chk_swstby_hold: assert property (
		CE && SW_STBY && !HW_STBY && !s_r.wr_pend |=>
			$stable(s_r.ctrl))
		else $error("control changed in software standby");

	chk_ctrl_rsvd_ones: assert property (
		CE && addr_take && decode(HADDR) == P1FS_SEL_CTRL |=>
			HRDATA[7] && HRDATA[2:0] == 3'h7)
		else $error("reserved control bits not read as one");

	chk_ext_interrupt_line1_route: assert property (
		CE && ext_interrupt_line1_sel |=> PIN_OE_N[`P1FS_PIN_EXT_INTERRUPT_LINE1] &&
			EXT_INTERRUPT_LINE1_N == $past(PIN_IN[6]))
		else $error("pin 6 not routed to line 1");

	chk_ext_interrupt_line0_read: assert property (
		CE && ext_interrupt_line0_sel && addr_take &&
		decode(HADDR) == P1FS_SEL_DATA |=>
			HRDATA[5] == $past(PIN_IN[5]))
		else $error("claimed pin 5 level not readable");

	chk_nmi_edge: assert property (
		CE && s_r.nmi_prev && !NMI_PIN && !nmi_rise ##1 CE
		|-> NMI_REQ ##1 !NMI_REQ || !$past(CE))
		else $error("falling edge did not raise nmi");

	chk_bus_release: assert property (
		CE && bus_release_select_on |=> !PIN_OE_N[2] && PIN_OE_N[3] &&
			PIN_OUT[2] == $past(BUS_ACK_OUT))
		else $error("bus release roles wrong");

	chk_single_chip: assert property (
		CE && !MODE_EXP && s_r.dir[3] && s_r.dir[2] |=>
			!PIN_OE_N[3] && !PIN_OE_N[2])
		else $error("single-chip pins 3 and 2 not plain io");

	chk_timer_pin: assert property (
		CE && tmr_on |=> !PIN_OE_N[7] &&
			PIN_OUT[7] == $past(TIMER_COMPARE_OUTPUT))
		else $error("timer output not on pin 7");

	chk_wait_pin: assert property (
		CE && wait_on |=> PIN_OE_N[4])
		else $error("pin 4 not a wait input");

	chk_clk_pin: assert property (
		CE && s_r.dir[0] |=> !PIN_OE_N[0] &&
			PIN_OUT[0] == $past(SYS_CLK))
		else $error("pin 0 does not carry system clock");

	chk_ext_interrupt_line0_route: assert property (
		CE && ext_interrupt_line0_sel |=> PIN_OE_N[`P1FS_PIN_EXT_INTERRUPT_LINE0] &&
			EXT_INTERRUPT_LINE0_N == $past(PIN_IN[5]))
		else $error("pin 5 not routed to line 0");

	chk_ext_interrupt_line1_idle: assert property (
		CE && !ext_interrupt_line1_sel |=> EXT_INTERRUPT_LINE1_N)
		else $error("line 1 active without its select bit");

	chk_mode_gate: assert property (
		CE && !MODE_EXP |=> BUS_REQUEST_IN_N && WAIT_IN_N)
		else $error("bus or wait role active in single-chip mode");

	chk_plain_dir: assert property (
		CE && !ext_interrupt_line1_sel |=> PIN_OE_N[6] == !$past(s_r.dir[6]))
		else $error("unclaimed pin 6 ignores its direction bit");

	chk_eclk_pin: assert property (
		CE && s_r.dir[1] |=> !PIN_OE_N[1] &&
			PIN_OUT[1] == $past(E_CLK))
		else $error("pin 1 does not carry e clock");

	chk_data_latch: assert property (
		CE && addr_take && decode(HADDR) == P1FS_SEL_DATA &&
		s_r.dir[7] && !tmr_on |=> HRDATA[7] == $past(s_r.latch[7]))
		else $error("output pin 7 read not from latch");

	chk_bus_request_in_dir: assert property (
		CE && bus_release_select_on && !s_r.dir[2] && s_r.dir[3] |=>
			PIN_OE_N[3] && !PIN_OE_N[2])
		else $error("bus release roles follow direction bits");

	chk_reset_vals: assert property (
		$fell(RST) |-> s_r.dir == `P1FS_DIR_RST &&
			s_r.ctrl == `P1FS_CTRL_RST)
		else $error("reset values not loaded");

	chk_wait_idle: assert property (
		CE && !wait_on |=> WAIT_IN_N)
		else $error("wait input active without its role");

	chk_nmi_quiet: assert property (
		CE && NMI_PIN == s_r.nmi_prev |=> !NMI_REQ)
		else $error("nmi raised without an edge");

	cov_hw_stby: cover property (CE && HW_STBY);
	cov_nmi_rise: cover property (CE && nmi_rise ##1 NMI_REQ);
	cov_ctrl_write: cover property (
		s_r.wr_pend && s_r.wr_sel == P1FS_SEL_CTRL && CE);
	cov_bus_rel: cover property (CE && bus_release_select_on ##1 !PIN_OE_N[2]);
	cov_data_read: cover property (
		CE && addr_take && !HWRITE && decode(HADDR) == P1FS_SEL_DATA);

endmodule

// ===== test/p1fs_far_model.sv
`timescale 1ns/1ns
module p1fs_far_model (
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] ext,
	output logic [7:0] pin_in
);
	// Wire level: design wins where it drives, outside source elsewhere
	assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule

// ===== test/test_port1_pin_function_select.sv
`timescale 1ns/1ns
`include "p1fs_params.svh"
module test_port1_pin_function_select;
	import p1fs_pkg::*;
	localparam logic [31:0] A_DIR = {14'h0, `P1FS_DIR_IDX, 2'b00};
	localparam logic [31:0] A_DAT = {14'h0, `P1FS_DATA_IDX, 2'b00};
	localparam logic [31:0] A_CTL = {14'h0, `P1FS_CTRL_IDX, 2'b00};
	logic CLK = 1'b0, RST = 1'b1, CE = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
	logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
	logic [1:0] HTRANS = 2'h0;
	logic [2:0] HSIZE = 3'h2;
	logic HREADY, HREADYOUT, HRESP, MODE_EXP = 1'b0;
	logic HW_STBY = 1'b0, SW_STBY = 1'b0, TIMER_COMPARE_OUTPUT = 1'b0;
	logic [3:0] TIMER_OUTPUT_SELECT = 4'h0;
	logic WAIT_MODE_SELECT_HIGH = 1'b0, BUS_ACK_OUT = 1'b0;
	logic E_CLK = 1'b1, SYS_CLK = 1'b0, NMI_PIN = 1'b1;
	logic [7:0] PIN_IN, PIN_OUT, PIN_OE_N, ext = 8'h3c;
	logic EXT_INTERRUPT_LINE1_N, EXT_INTERRUPT_LINE0_N, WAIT_IN_N;
	logic BUS_REQUEST_IN_N, NMI_REQ;
	int fail_count = 0, n_compared = 0;
	assign HREADY = HREADYOUT;
	p1fs_top dut_u (.*);
	p1fs_far_model far_u (.pin_out(PIN_OUT), .pin_oe_n(PIN_OE_N),
		.ext(ext), .pin_in(PIN_IN));
	initial begin
		forever #25 CLK = ~CLK;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= w;
		do @(posedge CLK); while (HREADY !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADY !== 1'b1);
		r = HRDATA;
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] r;
		xfer(1'b1, a, {24'hffffff, d}, r);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(r, exp);
	endtask
	// Registered pins need a couple of edges after any input change
	task automatic settle();
		repeat (3) @(posedge CLK);
		#1;
	endtask
	task automatic t_reset();
		settle();
		rd(A_CTL, 32'h87);
		rd(A_DIR, 32'hff);
		rd(32'h100, 32'h0);
		chk(PIN_OE_N, 8'hfc);
		chk(PIN_OUT[1:0], {E_CLK, SYS_CLK});
		rd(A_DAT, {24'h0, ext[7:2], E_CLK, SYS_CLK});
		$display("reset test done");
	endtask
	task automatic t_ctrl_and_data();
		wr(A_CTL, 8'h00);
		rd(A_CTL, 32'h87);
		wr(A_CTL, 8'h78);
		rd(A_CTL, 32'hff);
		wr(A_CTL, 8'h87);
		wr(A_DIR, 8'hf0);
		wr(A_DAT, 8'ha5);
		settle();
		chk(PIN_OE_N, 8'h0f);
		chk(PIN_OUT[7:4], 4'ha);
		rd(A_DAT, {24'h0, 4'ha, ext[3:0]});
		$display("control and data test done");
	endtask
	task automatic t_irq();
		logic [31:0] r;
		ext <= 8'h40;
		wr(A_DIR, 8'hff);
		wr(A_CTL, 8'h60);
		settle();
		chk(PIN_OE_N[6:5], 2'b11);
		chk({EXT_INTERRUPT_LINE1_N, EXT_INTERRUPT_LINE0_N}, 2'b10);
		xfer(1'b0, A_DAT, 32'h0, r);
		chk(r[6:5], 2'b10);
		$display("interrupt role test done");
	endtask
	task automatic t_nmi();
		logic [31:0] n;
		for (int e = 0; e < 2; e++) begin
			wr(A_CTL, e ? 8'h10 : 8'h00);
			NMI_PIN <= e[0] ? 1'b0 : 1'b1;
			settle();
			n = 0;
			NMI_PIN <= ~NMI_PIN;
			repeat (5) begin
				@(posedge CLK);
				#1;
				n += NMI_REQ;
			end
			chk(n, 1);
			NMI_PIN <= ~NMI_PIN;
			settle();
			chk(NMI_REQ, 1'b0);
		end
		$display("nmi edge test done");
	endtask
	task automatic t_bus_wait();
		ext <= 8'h10;
		BUS_ACK_OUT <= 1'b1;
		WAIT_MODE_SELECT_HIGH <= 1'b1;
		MODE_EXP <= 1'b1;
		wr(A_DIR, 8'hff);
		wr(A_CTL, 8'h08);
		settle();
		chk({PIN_OE_N[4:2], PIN_OUT[2]}, 4'b1101);
		chk({BUS_REQUEST_IN_N, WAIT_IN_N}, 2'b01);
		MODE_EXP <= 1'b0;
		settle();
		chk(PIN_OE_N[4:2], 3'b000);
		chk({BUS_REQUEST_IN_N, WAIT_IN_N}, 2'b11);
		WAIT_MODE_SELECT_HIGH <= 1'b0;
		$display("bus release and wait test done");
	endtask
	task automatic t_timer();
		wr(A_DIR, 8'h00);
		for (int i = 0; i < 5; i++) begin
			TIMER_OUTPUT_SELECT <= (i < 4) ? 4'(1 << i) : 4'h0;
			TIMER_COMPARE_OUTPUT <= i[0];
			settle();
			chk(PIN_OE_N[7], i == 4);
			if (i < 4) chk(PIN_OUT[7], i[0]);
		end
		$display("timer output test done");
	endtask
	task automatic t_standby();
		wr(A_CTL, 8'h78);
		SW_STBY <= 1'b1;
		settle();
		rd(A_CTL, 32'hff);
		SW_STBY <= 1'b0;
		HW_STBY <= 1'b1;
		settle();
		HW_STBY <= 1'b0;
		settle();
		rd(A_CTL, 32'h87);
		chk(PIN_OE_N, 8'hff);
		$display("standby test done");
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge CLK);
		fail_count++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(posedge CLK);
		RST <= 1'b0;
		t_reset();
		t_ctrl_and_data();
		t_irq();
		t_nmi();
		t_bus_wait();
		t_timer();
		t_standby();
		report_and_stop();
	end
endmodule
